// file: amp_cmp_defs.svh
// Constants for the amplifier/comparator control block
// How it works
// - Both enables set: amplifier wins; unit runs as amplifier only with exactly one of reference/pad select set.
// - Unit 0 enabled: pins P2.5/P2.6/P2.7 switch to analog signals.
// - Unit 1 enabled: pins P2.2/P2.3/P2.4 switch to analog signals.
// - Decode function from four bits; both enables clear keeps pins general I/O.
// - Pad select set, reference clear: positive input from external pin.
// - Reference select set: internal reference; comparator mode even with pad set.
// - Per-comparator hysteresis enable: 0 off, 1 on.
// - Read-only compare result: 1 when positive above negative.
// - Edge mode 00 toggle, 01 rising, 10 falling, 11 reserved.
// - Flag set by selected edge, held until software clears it.
// - Unit-0 route bit: 0 channel select field, 1 dedicated converter channel.
`ifndef AMP_CMP_DEFS_SVH
`define AMP_CMP_DEFS_SVH
`define ADDR_PIN_SEL   8'hf6
`define ADDR_CMP0_CTL  8'hfe
`define ADDR_CMP1_CTL  8'hff
`define RST_PIN_SEL    8'h00
`define RST_CMP_CTL    8'h00
`define BIT_HYS        7
`define BIT_RESULT     6
`define BIT_MODE_HI    5
`define BIT_MODE_LO    4
`define BIT_FLAG       3
`define BIT_ROUTE      0
`define EDGE_TOGGLE    2'h0
`define EDGE_RISE      2'h1
`define EDGE_FALL      2'h2
`endif

// file: amp_cmp_pkg.sv
// Types for the amplifier/comparator control block
package amp_cmp_pkg;
    typedef enum logic [3:0] {
        FN_GPIO  = 4'h1,
        FN_COMP  = 4'h2,
        FN_AMP   = 4'h4,
        FN_ILLEG = 4'h8
    } unit_fn_e;
    typedef struct packed {
        logic amp_en;
        logic cmp_en;
        logic ref_sel;
        logic pad_sel;
    } unit_cfg_s;
    typedef struct packed {
        logic amp_on;
        logic cmp_on;
        logic pins_analog;
        logic pos_from_ref;
        logic pos_from_pad;
        logic hys_on;
    } unit_ctl_s;
endpackage

// file: amp_comparator_control.sv
// Register and control logic for two amplifier/comparator units
`timescale 1ns/100ps
`default_nettype none
`include "amp_cmp_defs.svh"
module amp_comparator_control
    import amp_cmp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Special function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_wr_i,
    output logic      [7:0] sfr_rdata_o,
    // Raw comparator outputs from the analog units
    input  wire logic [1:0] cmp_raw_i,
    // Analog unit controls
    output unit_ctl_s       unit0_ctl_o,
    output unit_ctl_s       unit1_ctl_o,
    output logic            amp_output_converter_route_o,
    output logic [1:0]      event_flag_o
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic unit_fn_e decode_fn(input unit_cfg_s c);
        unit_fn_e f;
        f = FN_ILLEG;
        if (!c.amp_en && !c.cmp_en)
            f = FN_GPIO;
        else if (c.amp_en)
        begin
            if (c.ref_sel ^ c.pad_sel)
                f = FN_AMP;
        end
        else if (c.ref_sel || c.pad_sel)
            f = FN_COMP;
        return f;
    endfunction

    function automatic unit_ctl_s make_ctl(input unit_cfg_s c, input logic hys);
        unit_ctl_s s;
        unit_fn_e  f;
        f = decode_fn(c);
        s.amp_on       = (f == FN_AMP);
        s.cmp_on       = (f == FN_COMP);
        s.pins_analog  = c.amp_en || c.cmp_en;
        s.pos_from_ref = (f != FN_GPIO) && (f != FN_ILLEG) && c.ref_sel;
        s.pos_from_pad = (f != FN_GPIO) && (f != FN_ILLEG)
                         && c.pad_sel && !c.ref_sel;
        s.hys_on       = hys;
        return s;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] pin_sel_r;
    logic [1:0] hys_r;
    logic [1:0] mode_r [2];
    logic [1:0] flag_r;
    logic       route_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] prev_r;
    logic [1:0] edge_hit;
    logic       wr0;
    logic       wr1;

    assign wr0 = sfr_wr_i && (sfr_addr_i == `ADDR_CMP0_CTL);
    assign wr1 = sfr_wr_i && (sfr_addr_i == `ADDR_CMP1_CTL);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pin_sel_r <= `RST_PIN_SEL;
        else if (sfr_wr_i && (sfr_addr_i == `ADDR_PIN_SEL))
            pin_sel_r <= sfr_wdata_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hys_r     <= 2'h0;
            mode_r[0] <= 2'h0;
            mode_r[1] <= 2'h0;
            route_r   <= 1'b0;
        end
        else
        begin
            if (wr0)
            begin
                hys_r[0]  <= sfr_wdata_i[`BIT_HYS];
                mode_r[0] <= sfr_wdata_i[`BIT_MODE_HI:`BIT_MODE_LO];
                route_r   <= sfr_wdata_i[`BIT_ROUTE];
            end
            if (wr1)
            begin
                hys_r[1]  <= sfr_wdata_i[`BIT_HYS];
                mode_r[1] <= sfr_wdata_i[`BIT_MODE_HI:`BIT_MODE_LO];
            end
        end
    end

    // ****************************************
    // Comparator input sync and edge detect
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            prev_r  <= 2'h0;
        end
        else
        begin
            sync1_r <= cmp_raw_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            unique case (mode_r[u])
                `EDGE_TOGGLE: edge_hit[u] = sync2_r[u] ^ prev_r[u];
                `EDGE_RISE:   edge_hit[u] = sync2_r[u] & ~prev_r[u];
                `EDGE_FALL:   edge_hit[u] = ~sync2_r[u] & prev_r[u];
                default:      edge_hit[u] = 1'b0;
            endcase
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flag_r <= 2'h0;
        else
        begin
            for (int u = 0; u < 2; u++)
            begin
                if (edge_hit[u])
                    flag_r[u] <= 1'b1;
                else if ((u == 0 ? wr0 : wr1) && !sfr_wdata_i[`BIT_FLAG])
                    flag_r[u] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            unit0_ctl_o                  <= '0;
            unit1_ctl_o                  <= '0;
            amp_output_converter_route_o <= 1'b0;
            event_flag_o                 <= 2'h0;
        end
        else
        begin
            unit0_ctl_o  <= make_ctl(pin_sel_r[7:4], hys_r[0]);
            unit1_ctl_o  <= make_ctl(pin_sel_r[3:0], hys_r[1]);
            amp_output_converter_route_o <= route_r;
            event_flag_o <= flag_r;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sfr_rdata_o <= 8'h00;
        else
        begin
            unique case (sfr_addr_i)
                `ADDR_PIN_SEL:  sfr_rdata_o <= pin_sel_r;
                `ADDR_CMP0_CTL: sfr_rdata_o <= {hys_r[0], sync2_r[0], mode_r[0],
                                                flag_r[0], 2'h0, route_r};
                `ADDR_CMP1_CTL: sfr_rdata_o <= {hys_r[1], sync2_r[1], mode_r[1],
                                                flag_r[1], 3'h0};
                default:        sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    chk_amp_priority: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[7:6] == 2'b11 && (pin_sel_r[5] ^ pin_sel_r[4]))
        |=> unit0_ctl_o.amp_on && !unit0_ctl_o.cmp_on)
        else $error("amplifier priority lost");
    chk_pins_unit0: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[7] || pin_sel_r[6]) |=> unit0_ctl_o.pins_analog)
        else $error("unit0 pins not switched");
    chk_pins_unit1: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[3] || pin_sel_r[2]) |=> unit1_ctl_o.pins_analog)
        else $error("unit1 pins not switched");
    chk_gpio_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[3:2] == 2'b00) |=> !unit1_ctl_o.pins_analog && !unit1_ctl_o.amp_on
        && !unit1_ctl_o.cmp_on) else $error("gpio unit not idle");
    chk_pad_source: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[6:4] == 3'b101 && !pin_sel_r[7]) |=> unit0_ctl_o.pos_from_pad)
        else $error("pad source not taken");
    chk_ref_source: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pin_sel_r[3:0] == 4'b0111) |=> unit1_ctl_o.pos_from_ref
        && !unit1_ctl_o.pos_from_pad) else $error("reference source not taken");
    chk_hys_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr0 |=> ##1 unit0_ctl_o.hys_on == $past(sfr_wdata_i[`BIT_HYS], 2))
        else $error("hysteresis not applied");
    chk_result_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (sfr_addr_i == `ADDR_CMP0_CTL) |=> sfr_rdata_o[`BIT_RESULT] == $past(sync2_r[0]))
        else $error("result bit wrong");
    chk_rise_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode_r[0] == `EDGE_RISE && $rose(sync2_r[0])) |=> flag_r[0])
        else $error("rising edge missed");
    chk_flag_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (flag_r[1] && !wr1) |=> flag_r[1]) else $error("flag dropped");
    chk_route_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr0 |=> ##1 amp_output_converter_route_o == $past(sfr_wdata_i[`BIT_ROUTE], 2))
        else $error("route not applied");
    cov_amp_mode: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        unit0_ctl_o.amp_on);
    cov_cmp_mode: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        unit1_ctl_o.cmp_on);
    cov_flag_set: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(flag_r[0]));
    cov_set_clear: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        edge_hit[1] && wr1 && !sfr_wdata_i[`BIT_FLAG]);

endmodule
`default_nettype wire

// file: amp_comparator_control_tb.sv
// Self-checking testbench for the amplifier/comparator control block
`timescale 1ns/100ps
`default_nettype none
`include "amp_cmp_defs.svh"
module amp_comparator_control_tb
    import amp_cmp_pkg::*;
;
    logic        clk_i;
    logic        arst_n_i;
    logic [7:0]  sfr_addr_i;
    logic [7:0]  sfr_wdata_i;
    logic        sfr_wr_i;
    logic [7:0]  sfr_rdata_o;
    logic [1:0]  cmp_raw_i;
    unit_ctl_s   unit0_ctl_o;
    unit_ctl_s   unit1_ctl_o;
    logic        route_o;
    logic [1:0]  event_flag_o;
    logic        obs;
    logic [10:0] note_q[$];
    logic [10:0] note;
    int          bad_count;
    int          n_checks;

    amp_comparator_control amp_comparator_control_i (
        .clk_i                        (clk_i),
        .arst_n_i                     (arst_n_i),
        .sfr_addr_i                   (sfr_addr_i),
        .sfr_wdata_i                  (sfr_wdata_i),
        .sfr_wr_i                     (sfr_wr_i),
        .sfr_rdata_o                  (sfr_rdata_o),
        .cmp_raw_i                    (cmp_raw_i),
        .unit0_ctl_o                  (unit0_ctl_o),
        .unit1_ctl_o                  (unit1_ctl_o),
        .amp_output_converter_route_o (route_o),
        .event_flag_o                 (event_flag_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Monitor: compares oldest note on demand
    // ****************************************
    always @(negedge clk_i)
    begin
        if (obs)
        begin
            note = note_q.pop_front();
            case (note[10:8])
                3'h0:    chk(sfr_rdata_o, note[7:0]);
                3'h1:    chk({2'h0, unit0_ctl_o}, note[7:0]);
                3'h2:    chk({2'h0, unit1_ctl_o}, note[7:0]);
                default: chk({5'h0, route_o, event_flag_o}, note[7:0]);
            endcase
        end
    end

    task automatic note_exp(input logic [2:0] sel, input logic [7:0] exp);
        note_q.push_back({sel, exp});
        obs = 1'b1;
        @(negedge clk_i);
        #1 obs = 1'b0;
        #1;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        waitc(1);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        waitc(1);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        waitc(1);
        sfr_addr_i = a;
        waitc(1);
        note_exp(3'h0, exp);
    endtask

    // Expected unit controls from {amp, cmp, ref, pad}
    function automatic logic [7:0] exp_ctl(input logic [3:0] c, input logic hys);
        logic amp;
        logic cmp;
        amp = c[3] & (c[1] ^ c[0]);
        cmp = ~c[3] & c[2] & (c[1] | c[0]);
        return {2'h0, amp, cmp, c[3] | c[2], (amp | cmp) & c[1], (amp | cmp) & c[0] & ~c[1], hys};
    endfunction

    task automatic cfg(input logic [7:0] v, input logic hys);
        wr(8'hf6, v);
        rd(8'hf6, v);
        note_exp(3'h1, exp_ctl(v[7:4], hys));
        note_exp(3'h2, exp_ctl(v[3:0], hys));
    endtask

    task automatic flag(input logic [7:0] a, input int u, input logic [1:0] m,
                        input logic lvl, input logic f);
        waitc(6);
        rd(a, {1'b0, lvl, m, f, 3'h0});
        note_exp(3'h3, {6'h0, u ? {f, 1'b0} : {1'b0, f}});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        arst_n_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        cmp_raw_i = 2'h0;
        obs = 1'b0;
        bad_count = 0;
        n_checks = 0;
        void'($urandom(32'hf0c5));
        waitc(10);
        arst_n_i = 1'b1;
        rd(8'hf6, 8'h00);
        rd(8'hfe, 8'h00);
        rd(8'hff, 8'h00);
        wr(8'h80, 8'hff);
        rd(8'h80, 8'h00);
        note_exp(3'h3, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            cfg({i[3:0], 4'($urandom)}, 1'b0);
            cfg({4'($urandom), i[3:0]}, 1'b0);
        end
        // Writes of one to flag, result and spare bits are dropped
        wr(8'hfe, 8'hff);
        rd(8'hfe, 8'hb1);
        wr(8'hff, 8'hf0);
        rd(8'hff, 8'hb0);
        cfg(8'h59, 1'b1);
        note_exp(3'h3, 8'h04);
        for (int u = 0; u < 2; u++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                wr(u ? 8'hff : 8'hfe, {2'h0, m[1:0], 4'h0});
                cmp_raw_i[u] = 1'b1;
                flag(u ? 8'hff : 8'hfe, u, m[1:0], 1'b1, m == 0 || m == 1);
                wr(u ? 8'hff : 8'hfe, {2'h0, m[1:0], 4'h0});
                cmp_raw_i[u] = 1'b0;
                flag(u ? 8'hff : 8'hfe, u, m[1:0], 1'b0, m == 0 || m == 2);
            end
        end
        // Reset again in mid-run
        waitc(1);
        arst_n_i = 1'b0;
        waitc(2);
        arst_n_i = 1'b1;
        rd(8'hf6, 8'h00);
        rd(8'hfe, 8'h00);
        rd(8'hff, 8'h00);
        note_exp(3'h3, 8'h00);
        cfg(8'h00, 1'b0);
        final_report();
    end

    initial
    begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
